// >>> biu_defs.vh
/*
  constants for the bus interface unit: status codes, segment codes,
  address layout and timing.
  assumes a single 40 MHz clock and an apb master for the request registers.
*/
// Operation
// RQ1 - present a 20-bit byte address, one megabyte linear space
// RQ2 - segments span 64K bytes and start on 16-byte boundaries
// RQ3 - physical address is segment base times sixteen plus offset, 20 bits
// RQ4 - instruction prefetch always uses the code segment base
// RQ5 - stack pushes, pops and base-pointer references use the stack segment
// RQ6 - string destinations use extra segment; explicit overrides are honoured
// RQ7 - words at any address; low byte lower address, high byte next
// RQ8 - each word operand becomes two successive byte bus cycles
// RQ9 - after reset fetching starts at the fixed location near memory top
// RQ10 - lowest 1 KB holds 256 four-byte vectors of offset and segment
// RQ11 - strap selects minimum mode (own controls) or maximum mode (status)
// RQ12 - minimum mode drives transceiver enable, direction and address strobe
// RQ13 - maximum mode gives three-bit cycle status for an external controller
// RQ14 - low byte muxed address/data, top nibble muxed status, middle held
// RQ15 - cycles last four clocks: address, turnaround, then data twice
// RQ16 - not ready inserts one-clock wait states between third and fourth
// RQ17 - idle states between cycles carry no bus activity
// RQ18 - address strobe pulses in the first state of every cycle
// RQ19 - cycle status 000..111: inta, io rd, io wr, halt, fetch, rd, wr, passive
// RQ20 - upper status bits ride top address lines from second to fourth state
// RQ21 - segment status 00 extra, 01 stack, 10 code or none, 11 data
// RQ22 - fifth status bit mirrors interrupt enable, sixth always zero
// RQ23 - io cycles put a 16-bit port on low lines, top nibble zero
`ifndef BIU_DEFS_VH
`define BIU_DEFS_VH

`define ST_INTA 3'h0
`define ST_IORD 3'h1
`define ST_IOWR 3'h2
`define ST_HALT 3'h3
`define ST_FETCH 3'h4
`define ST_MEMRD 3'h5
`define ST_MEMWR 3'h6
`define ST_PASSIVE 3'h7

`define SEG_EXTRA 2'h0
`define SEG_STACK 2'h1
`define SEG_CODE 2'h2
`define SEG_DATA 2'h3

`define REF_FETCH 3'h0
`define REF_STACK 3'h1
`define REF_DATA 3'h2
`define REF_STRDST 3'h3
`define REF_BPBASE 3'h4
`define REF_IO 3'h5
`define REF_VECTOR 3'h6

`define RESET_CODE_SEG 16'hFFFF
`define RESET_OFFSET 16'h0000
`define VECTOR_SHIFT 2
`define VECTOR_SEG 16'h0000
`define SEG_SHIFT 4
`define NIBBLE_ZERO 4'h0
`define APB_PERIOD_NS 25

`define A_CTRL 12'h000
`define A_CODESEG 12'h004
`define A_DATASEG 12'h008
`define A_STACKSEG 12'h00C
`define A_EXTRASEG 12'h010
`define A_OFFSET 12'h014
`define A_WDATA 12'h018
`define A_CMD 12'h01C
`define A_STATUS 12'h020
`define A_RDATA 12'h024
`define A_ADDR 12'h028

`define C_MINMODE_BIT 0
`define C_IE_BIT 1
`define C_OVR_EN_BIT 2
`define C_OVR_LSB 3
`define C_OVR_MSB 4
`define CMD_REF_LSB 0
`define CMD_REF_MSB 2
`define CMD_WR_BIT 3
`define CMD_WORD_BIT 4
`define CMD_HALT_BIT 5
`define CMD_INTA_BIT 6

`endif

// >>> bus_interface_unit.v
/*
  bus interface unit: forms 20-bit physical addresses, splits words into
  byte cycles and runs t1..t4 multiplexed cycles with waits and idles.
  assumes an apb master issuing requests, and a strap and ready that come
  from pins; the strap passes three flip-flops and ready two before use.
*/
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "biu_defs.vh"

module bus_interface_unit (
  input wire clock_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire config_mode_strap_i,
  input wire ready_i,
  input wire [7:0] muxed_addr_data_low_i,
  output wire [7:0] muxed_addr_data_low_o,
  output wire muxed_addr_data_low_oe_o,
  output wire [7:0] addr_middle_byte_o,
  output wire [3:0] addr_top_nibble_status_o,
  output wire addr_strobe_o,
  output wire transceiver_enable_n_o,
  output wire transmit_receive_dir_o,
  output wire io_not_mem_o,
  output wire cycle_status_bit0_o,
  output wire cycle_status_bit1_o,
  output wire cycle_status_bit2_o
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_T1 = 6'h02;
  localparam [5:0] S_T2 = 6'h04;
  localparam [5:0] S_T3 = 6'h08;
  localparam [5:0] S_TW = 6'h10;
  localparam [5:0] S_T4 = 6'h20;

  reg [1:0] strap_sync_r;
  reg [1:0] ready_sync_r;
  reg [15:0] code_seg_r;
  reg [15:0] data_seg_r;
  reg [15:0] stack_seg_r;
  reg [15:0] extra_seg_r;
  reg [15:0] offset_r;
  reg [15:0] wdata_r;
  reg [15:0] rdata_r;
  reg min_mode_r;
  reg int_enable_r;
  reg ovr_en_r;
  reg [1:0] ovr_seg_r;
  reg [2:0] ref_r;
  reg wr_r;
  reg word_r;
  reg halt_r;
  reg inta_r;
  reg busy_r;
  reg second_r;
  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [19:0] addr_r;
  reg [2:0] status_r;
  reg [1:0] segsel_r;
  reg [7:0] ad_out_r;
  reg ad_oe_r;
  reg [7:0] mid_r;
  reg [3:0] top_r;
  reg strobe_r;
  reg den_n_r;
  reg dtr_r;
  reg io_r;
  reg [2:0] cstat_r;
  reg [1:0] seg_sel;
  reg [15:0] base_sel;
  reg [19:0] phys_addr;
  reg [2:0] cyc_code;
  reg [31:0] rd_mux;
  wire setup_wr;
  wire [15:0] cur_off;
  wire is_io;
  wire ready_s;
  wire byte_sel;

  assign ready_s = ready_sync_r[1];
  assign setup_wr = psel_i & penable_i & pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  // the second byte's address is latched at the t4 edge, the same edge at which second_r rises
  assign byte_sel = second_r | (state_r == S_T4);
  assign cur_off = offset_r + {15'h0000, byte_sel}; // [RQ7]
  assign is_io = (ref_r == `REF_IO);

  always @* begin
    seg_sel = `SEG_DATA;
    case (ref_r)
      `REF_FETCH: seg_sel = `SEG_CODE; // [RQ4]
      `REF_STACK: seg_sel = `SEG_STACK; // [RQ5]
      `REF_BPBASE: seg_sel = `SEG_STACK; // [RQ5]
      `REF_STRDST: seg_sel = `SEG_EXTRA; // [RQ6]
      `REF_IO: seg_sel = `SEG_CODE;
      `REF_VECTOR: seg_sel = `SEG_CODE;
      default: seg_sel = `SEG_DATA;
    endcase
    // fetches, pushes, pops, string destinations, io and vectors ignore the prefix; others follow it
    if (ovr_en_r && ref_r != `REF_FETCH && ref_r != `REF_STRDST && ref_r != `REF_STACK &&
        ref_r != `REF_IO && ref_r != `REF_VECTOR) begin
      seg_sel = ovr_seg_r; // [RQ6]
    end
    case (seg_sel)
      `SEG_EXTRA: base_sel = extra_seg_r;
      `SEG_STACK: base_sel = stack_seg_r;
      `SEG_CODE: base_sel = code_seg_r;
      default: base_sel = data_seg_r;
    endcase
    if (ref_r == `REF_VECTOR) begin
      // vectors live in the low 1 KB: type times four, segment zero
      phys_addr = {`VECTOR_SEG, 4'h0} +
                  {10'h000, offset_r[7:0], 2'h0} + {19'h00000, byte_sel}; // [RQ10]
    end else if (is_io) begin
      phys_addr = {`NIBBLE_ZERO, cur_off}; // [RQ23]
    end else begin
      // segment on a 16-byte boundary, offset reach 64K, wraps at 1 MB
      phys_addr = {base_sel, 4'h0} + {4'h0, cur_off}; // [RQ1] [RQ2] [RQ3]
    end
    if (halt_r) begin
      cyc_code = `ST_HALT;
    end else if (inta_r) begin
      cyc_code = `ST_INTA;
    end else if (is_io) begin
      cyc_code = wr_r ? `ST_IOWR : `ST_IORD;
    end else if (ref_r == `REF_FETCH) begin
      cyc_code = `ST_FETCH;
    end else begin
      cyc_code = wr_r ? `ST_MEMWR : `ST_MEMRD;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: if (busy_r) state_nxt = S_T1; // [RQ17]
      S_T1: state_nxt = S_T2;
      S_T2: state_nxt = S_T3;
      S_T3: state_nxt = ready_s ? S_T4 : S_TW; // [RQ16]
      S_TW: state_nxt = ready_s ? S_T4 : S_TW; // [RQ16]
      S_T4: state_nxt = (word_r && !second_r) ? S_T1 : S_IDLE; // [RQ8]
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_sync_r <= 2'h0;
      ready_sync_r <= 2'h0;
    end else begin
      strap_sync_r <= {strap_sync_r[0], config_mode_strap_i};
      ready_sync_r <= {ready_sync_r[0], ready_i};
    end
  end

  // register file and request handshake
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_seg_r <= `RESET_CODE_SEG; // [RQ9]
      data_seg_r <= 16'h0000;
      stack_seg_r <= 16'h0000;
      extra_seg_r <= 16'h0000;
      offset_r <= `RESET_OFFSET; // [RQ9]
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      int_enable_r <= 1'b0;
      ovr_en_r <= 1'b0;
      ovr_seg_r <= 2'h0;
      ref_r <= `REF_FETCH;
      wr_r <= 1'b0;
      word_r <= 1'b0;
      halt_r <= 1'b0;
      inta_r <= 1'b0;
      busy_r <= 1'b0;
      second_r <= 1'b0;
      min_mode_r <= 1'b0;
    end else begin
      min_mode_r <= strap_sync_r[1]; // [RQ11]
      if (setup_wr && !busy_r) begin
        case (paddr_i)
          `A_CTRL: begin
            int_enable_r <= pwdata_i[`C_IE_BIT];
            ovr_en_r <= pwdata_i[`C_OVR_EN_BIT];
            ovr_seg_r <= pwdata_i[`C_OVR_MSB:`C_OVR_LSB];
          end
          `A_CODESEG: code_seg_r <= pwdata_i[15:0];
          `A_DATASEG: data_seg_r <= pwdata_i[15:0];
          `A_STACKSEG: stack_seg_r <= pwdata_i[15:0];
          `A_EXTRASEG: extra_seg_r <= pwdata_i[15:0];
          `A_OFFSET: offset_r <= pwdata_i[15:0];
          `A_WDATA: wdata_r <= pwdata_i[15:0];
          `A_CMD: begin
            ref_r <= pwdata_i[`CMD_REF_MSB:`CMD_REF_LSB];
            wr_r <= pwdata_i[`CMD_WR_BIT];
            word_r <= pwdata_i[`CMD_WORD_BIT];
            halt_r <= pwdata_i[`CMD_HALT_BIT];
            inta_r <= pwdata_i[`CMD_INTA_BIT];
            busy_r <= 1'b1;
            second_r <= 1'b0;
          end
          default: ;
        endcase
      end
      if (state_r == S_T4) begin
        if (!wr_r) begin
          // low byte first, high byte on the second cycle
          if (second_r) rdata_r[15:8] <= muxed_addr_data_low_i; // [RQ7]
          else rdata_r[7:0] <= muxed_addr_data_low_i; // [RQ7]
        end
        if (word_r && !second_r) begin
          second_r <= 1'b1; // [RQ8]
        end else begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  // pin drivers, all from flip-flops
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= S_IDLE;
      addr_r <= 20'h00000;
      status_r <= `ST_PASSIVE;
      segsel_r <= `SEG_CODE;
      ad_out_r <= 8'h00;
      ad_oe_r <= 1'b0;
      mid_r <= 8'h00;
      top_r <= 4'h0;
      strobe_r <= 1'b0;
      den_n_r <= 1'b1;
      dtr_r <= 1'b0;
      io_r <= 1'b0;
      cstat_r <= `ST_PASSIVE;
    end else begin
      state_r <= state_nxt;
      strobe_r <= 1'b0;
      ad_oe_r <= 1'b0;
      den_n_r <= 1'b1;
      cstat_r <= `ST_PASSIVE;
      case (state_nxt)
        S_T1: begin
          addr_r <= phys_addr;
          status_r <= cyc_code;
          segsel_r <= (is_io || ref_r == `REF_VECTOR) ? `SEG_CODE : seg_sel; // [RQ21]
          strobe_r <= min_mode_r; // [RQ18] [RQ12]
          ad_out_r <= phys_addr[7:0]; // [RQ14]
          ad_oe_r <= 1'b1;
          mid_r <= phys_addr[15:8]; // [RQ14]
          top_r <= phys_addr[19:16];
          dtr_r <= wr_r; // [RQ12]
          io_r <= is_io;
          cstat_r <= cyc_code; // [RQ13] [RQ19]
        end
        S_T2, S_T3, S_TW, S_T4: begin
          // status replaces the top nibble: s6 zero, s5 ie, s4..s3 segment
          top_r <= {1'b0, int_enable_r, segsel_r}; // [RQ20] [RQ22]
          ad_out_r <= second_r ? wdata_r[15:8] : wdata_r[7:0];
          ad_oe_r <= wr_r; // [RQ15]
          den_n_r <= !min_mode_r; // [RQ12]
          // status goes passive during t3 so the controller sees the end
          cstat_r <= (state_nxt == S_T2) ? status_r : `ST_PASSIVE; // [RQ13]
        end
        default: ;
      endcase
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (paddr_i)
      `A_CTRL: rd_mux = {27'h0000000, ovr_seg_r, ovr_en_r, int_enable_r, min_mode_r};
      `A_CODESEG: rd_mux = {16'h0000, code_seg_r};
      `A_DATASEG: rd_mux = {16'h0000, data_seg_r};
      `A_STACKSEG: rd_mux = {16'h0000, stack_seg_r};
      `A_EXTRASEG: rd_mux = {16'h0000, extra_seg_r};
      `A_OFFSET: rd_mux = {16'h0000, offset_r};
      `A_WDATA: rd_mux = {16'h0000, wdata_r};
      `A_STATUS: rd_mux = {24'h000000, state_r, second_r, busy_r};
      `A_RDATA: rd_mux = {16'h0000, rdata_r};
      `A_ADDR: rd_mux = {12'h000, addr_r};
      default: rd_mux = 32'h00000000;
    endcase
  end

  assign prdata_o = rd_mux;
  assign muxed_addr_data_low_o = ad_out_r;
  assign muxed_addr_data_low_oe_o = ad_oe_r;
  assign addr_middle_byte_o = mid_r;
  assign addr_top_nibble_status_o = top_r;
  assign addr_strobe_o = strobe_r;
  assign transceiver_enable_n_o = den_n_r;
  assign transmit_receive_dir_o = dtr_r;
  assign io_not_mem_o = io_r;
  // maximum mode only; minimum mode shows passive
  assign cycle_status_bit0_o = min_mode_r ? 1'b1 : cstat_r[0];
  assign cycle_status_bit1_o = min_mode_r ? 1'b1 : cstat_r[1];
  assign cycle_status_bit2_o = min_mode_r ? 1'b1 : cstat_r[2];

endmodule // bus_interface_unit

// >>> biu_asserts.sv
/*
  port checker for the bus interface unit, bound to its top module.
  assumes one clock domain with an async active-low reset.
*/
`timescale 1ns/100ps
module biu_asserts (
  input wire clock_i,
  input wire rst_n_i,
  input wire addr_strobe_o,
  input wire muxed_addr_data_low_oe_o,
  input wire [7:0] addr_middle_byte_o,
  input wire [3:0] addr_top_nibble_status_o,
  input wire transceiver_enable_n_o,
  input wire io_not_mem_o,
  input wire cycle_status_bit0_o,
  input wire cycle_status_bit1_o,
  input wire cycle_status_bit2_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_t1; addr_strobe_o; endsequence
  sequence s_t2; !addr_strobe_o && !transceiver_enable_n_o; endsequence
  property p_len; s_t1 |=> !addr_strobe_o [*3]; endproperty
  a_len: assert property (p_len) else $error("cycle shorter than four clocks");
  property p_mid; s_t1 |=> $stable(addr_middle_byte_o) [*3]; endproperty
  a_mid: assert property (p_mid) else $error("middle address moved in cycle");
  property p_den; s_t1 |=> s_t2; endproperty
  a_den: assert property (p_den) else $error("transceiver not enabled in second state");
  property p_oe; s_t1 |-> muxed_addr_data_low_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("address not driven in first state");
  property p_s6; s_t1 |=> !addr_top_nibble_status_o[3] [*3]; endproperty
  a_s6: assert property (p_s6) else $error("sixth status bit not zero");
  property p_io; s_t1 and io_not_mem_o |-> addr_top_nibble_status_o == 4'h0; endproperty
  a_io: assert property (p_io) else $error("io cycle top nibble not zero");
  // strobe and transceiver enable only exist in minimum mode, where status stays passive
  property p_pass; !transceiver_enable_n_o |->
    {cycle_status_bit2_o, cycle_status_bit1_o, cycle_status_bit0_o} == 3'h7; endproperty
  a_pass: assert property (p_pass) else $error("status not passive in minimum mode");
  property p_st; s_t1 ##1 s_t2 |=> $stable(addr_top_nibble_status_o) [*2]; endproperty
  a_st: assert property (p_st) else $error("upper status moved after second state");
endmodule // biu_asserts

bind bus_interface_unit biu_asserts chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .addr_strobe_o(addr_strobe_o), .muxed_addr_data_low_oe_o(muxed_addr_data_low_oe_o),
  .addr_middle_byte_o(addr_middle_byte_o), .addr_top_nibble_status_o(addr_top_nibble_status_o),
  .transceiver_enable_n_o(transceiver_enable_n_o), .io_not_mem_o(io_not_mem_o),
  .cycle_status_bit0_o(cycle_status_bit0_o), .cycle_status_bit1_o(cycle_status_bit1_o),
  .cycle_status_bit2_o(cycle_status_bit2_o));

// >>> biu_bus_device.sv
/*
  memory and io device on the far side of the bus interface unit.
  assumes minimum mode strobes; unwritten bytes read as a fixed address pattern.
*/
`timescale 1ns/100ps
module biu_bus_device (
  input wire clock_i,
  input wire stall_i,
  input wire addr_strobe_i,
  input wire io_i,
  input wire muxed_oe_i,
  input wire [7:0] ad_i,
  input wire [7:0] mid_i,
  input wire [3:0] top_i,
  output reg [7:0] ad_o,
  output reg ready_o
);
  reg [7:0] mem [int];
  reg [20:0] lat_r = 21'h0;
  initial ready_o = 1'b1;
  initial ad_o = 8'h00;
  always @(posedge clock_i) begin
    if (addr_strobe_i) begin
      lat_r <= {io_i, top_i, mid_i, ad_i};
    end else if (muxed_oe_i) begin
      mem[lat_r] = ad_i;
    end
    // the unit sees ready two clocks late, so a stall holds ready low in
    // random stretches that reach into t3 instead of reacting to the strobe
    ready_o <= stall_i ? ($urandom_range(3) == 0) : 1'b1;
    // while the unit drives, our side toggles so a stale byte never looks valid
    ad_o <= muxed_oe_i ? ~ad_o : mem.exists(lat_r) ? mem[lat_r] : lat_r[7:0] ^ lat_r[15:8];
  end
endmodule // biu_bus_device

// >>> test_bus_interface_unit.sv
/*
  self-checking bench for the bus interface unit with a device model.
  assumes a zero-wait apb slave and busy clearing at the end of the last cycle.
*/
`timescale 1ns/100ps
module test_bus_interface_unit;
  reg clock_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  reg [11:0] paddr_i = 12'h000;
  reg [31:0] pwdata_i = 32'h0, rd;
  reg strap = 1'b1, stall = 1'b0, t1_d = 1'b0, wr, wd, ovr, ie;
  reg [2:0] last_st = 3'h7, kind;
  reg [4:0] seg_st;
  reg [1:0] ovs, segc;
  reg [15:0] sg [0:3];
  reg [15:0] off, wdat;
  reg [19:0] a0, a1;
  reg [20:0] k0, k1;
  reg [7:0] mem_exp [int];
  wire [31:0] prdata_o;
  wire pready_o, slverr, strobe, oe, den_n, dir, io, s0, s1, s2, ready;
  wire [7:0] ad_o, ad_i, mid;
  wire [3:0] top;
  integer bad_count = 0, num_checks = 0, i, c;
  always #12.5 clock_i = ~clock_i;
  bus_interface_unit dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(slverr), .config_mode_strap_i(strap),
    .ready_i(ready), .muxed_addr_data_low_i(ad_i), .muxed_addr_data_low_o(ad_o),
    .muxed_addr_data_low_oe_o(oe), .addr_middle_byte_o(mid), .addr_top_nibble_status_o(top),
    .addr_strobe_o(strobe), .transceiver_enable_n_o(den_n), .transmit_receive_dir_o(dir),
    .io_not_mem_o(io), .cycle_status_bit0_o(s0), .cycle_status_bit1_o(s1),
    .cycle_status_bit2_o(s2));
  biu_bus_device dev (.clock_i(clock_i), .stall_i(stall), .addr_strobe_i(strobe), .io_i(io),
    .muxed_oe_i(oe), .ad_i(ad_o), .mid_i(mid), .top_i(top), .ad_o(ad_i), .ready_o(ready));
  always @(posedge clock_i) begin
    if ({s2, s1, s0} != 3'h7) last_st <= {s2, s1, s0};
    if (t1_d) seg_st <= {dir, top};
    t1_d <= strobe;
  end
  function [19:0] phys(input [15:0] s, input [15:0] o);
    phys = {s, 4'h0} + {4'h0, o};
  endfunction
  function [7:0] pat(input [20:0] k);
    pat = mem_exp.exists(k) ? mem_exp[k] : k[7:0] ^ k[15:8];
  endfunction
  function [11:0] sa(input integer s);
    sa = s == 0 ? 12'h010 : s == 1 ? 12'h00C : s == 2 ? 12'h004 : 12'h008;
  endfunction
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    begin
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      @(posedge clock_i);
      while (pready_o !== 1'b1) @(posedge clock_i);
      rd = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task check(input reg [31:0] got, input reg [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task op(input reg [6:0] cmd);
    begin
      last_st = 3'h7;
      apb(1'b1, 12'h01C, {25'h0, cmd});
      rd = 32'h1;
      while (rd[0] !== 1'b0) apb(1'b0, 12'h020, 32'h0);
    end
  endtask
  task final_report;
    begin
      if (bad_count == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // about 60 operations of under 100 cycles each; 80000 cycles is ample
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    rd = $urandom(32'h028E);
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    apb(1'b0, 12'h000, 32'h0);
    check(rd[0], 1'b1);
    op(7'h00);
    apb(1'b0, 12'h028, 32'h0);
    check(rd[19:0], 20'hFFFF0);
    apb(1'b0, 12'h030, 32'h0);
    check(rd, 32'h0);
    check(slverr, 1'b0);
    for (i = 0; i < 60; i = i + 1) begin
      if (i == 40) begin
        strap <= 1'b0;
        repeat (5) @(posedge clock_i);
      end
      for (c = 0; c < 4; c = c + 1) begin
        sg[c] = $urandom;
        apb(1'b1, sa(c), {16'h0, sg[c]});
      end
      kind = $urandom_range(6);
      wr = (kind inside {1, 2, 3, 5}) ? $urandom : 1'b0;
      {wd, ovr, ie, ovs} = $urandom;
      stall <= $urandom;
      off = $urandom_range(16'hFFFE);
      wdat = $urandom;
      segc = kind == 0 || kind > 4 ? 2'h2 : kind == 1 ? 2'h1 : kind == 3 ? 2'h0 :
        ovr ? ovs : kind == 2 ? 2'h3 : 2'h1;
      a0 = kind == 5 ? off : kind == 6 ? {off[7:0], 2'b00} : phys(sg[segc], off);
      a1 = kind == 5 ? off + 16'h1 : a0 + 20'h1;
      apb(1'b1, 12'h000, {27'h0, ovs, ovr, ie, 1'b0});
      apb(1'b1, 12'h014, {16'h0, off});
      apb(1'b1, 12'h018, {16'h0, wdat});
      op({2'b00, wd, wr, kind});
      apb(1'b0, 12'h028, 32'h0);
      check(rd[19:0], wd ? a1 : a0);
      k0 = {kind == 5, a0};
      k1 = {kind == 5, a1};
      if (strap) begin
        check(seg_st, {wr, 1'b0, ie, segc});
        if (wr) begin
          mem_exp[k0] = wdat[7:0];
          check(dev.mem[k0], wdat[7:0]);
          if (wd) mem_exp[k1] = wdat[15:8];
          if (wd) check(dev.mem[k1], wdat[15:8]);
        end else begin
          apb(1'b0, 12'h024, 32'h0);
          check(rd[7:0], pat(k0));
          if (wd) check(rd[15:8], pat(k1));
        end
      end else begin
        check(last_st, kind == 0 ? 3'h4 : kind == 5 ? {2'b00, wr} + 3'h1 : 3'h5 + wr);
      end
    end
    op(7'h20);
    check(last_st, 3'h3);
    op(7'h40);
    check(last_st, 3'h0);
    final_report;
  end
endmodule // test_bus_interface_unit
